//--- two_wire_eeprom_pkg.sv
/*
 * constants, types and state codes for the two-wire secure eeprom slave.
 * assumes a 40 MHz system clock and pins sampled through synchronisers.
 */
package two_wire_eeprom_pkg;

	// ----------------------------------------------------------------
	// framing
	// ----------------------------------------------------------------
	localparam int unsigned BYTE_BITS = 8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam int unsigned READ_FLAG_POS = 0;

	// ----------------------------------------------------------------
	// user memory
	// ----------------------------------------------------------------
	localparam int unsigned ZONE_COUNT = 16;
	localparam int unsigned ZONE_BITS = 1024;
	localparam int unsigned ZONE_BYTES = ZONE_BITS / BYTE_BITS;
	localparam int unsigned MEM_BYTES = ZONE_COUNT * ZONE_BYTES;
	localparam int unsigned PAGE_BYTES = 16;
	localparam int unsigned REQ_BITS = 8;
	localparam logic [6:0] LAST_OFFSET = 7'h7F;
	localparam logic [3:0] LAST_ZONE = 4'hF;
	localparam logic [7:0] RELEASED_BYTE = 8'hFF;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned INTERNAL_WRITE_DURATION_NS = 5000000;
	localparam int unsigned INTERNAL_WRITE_DURATION_MAX_NS = 7000000;
	localparam int unsigned INTERNAL_WRITE_CYCLES = INTERNAL_WRITE_DURATION_NS / CLK_PERIOD_NS;
	localparam int unsigned TIMER_BITS = 18;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] zone;
		logic [6:0] offset;
	} mem_addr_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} line_t;

	localparam line_t LINE_IDLE = 2'h3;

	typedef logic [ZONE_COUNT-1:0][REQ_BITS-1:0] zone_req_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_CMD = 7'h02,
		ST_ZONE = 7'h04,
		ST_ADDR = 7'h08,
		ST_WDATA = 7'h10,
		ST_RDATA = 7'h20,
		ST_WAIT = 7'h40
	} slave_state_t;

endpackage : two_wire_eeprom_pkg

//--- two_wire_eeprom_slave.sv
/*
 * two-wire serial slave front end with sixteen-zone user memory.
 * assumes an external pull-up on the data line and that the control
 * logic outside supplies per-zone grants and requirement codes.
 */
`timescale 1ns/10ps
// Operation
// - a data line change while the clock is high is a start or stop, never a data bit.
// - data falling with clock high is a start, and each command begins reception on it; a start while write_busy_o is high returns to idle instead.
// - data rising with clock high is a stop, which ends the current transaction.
// - a stop after a read sequence puts the device into standby.
// - addresses and data move in both directions as 8-bit words.
// - the device pulls data low in the ninth clock to acknowledge each received word; data words to a zone whose zone_grant_i bit is low are not acknowledged.
// - the self-timed write starts at the stop of a write sequence and ends within the write time.
// - user memory is sixteen individually addressed zones of 1024 bits.
// - access to a zone is refused until its security requirements are met.
// - zones with identical requirements behave as one larger contiguous zone.
// - incoming data is sampled on the rising clock edge and outgoing data shifted on the falling edge.
// - the data line is only pulled low or released, never driven high.
module two_wire_eeprom_slave
	import two_wire_eeprom_pkg::*;
#(
	parameter int unsigned WR_CYCLES = INTERNAL_WRITE_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [ZONE_COUNT-1:0] zone_grant_i,
	input wire zone_req_t zone_req_i,
	output logic standby_o,
	output logic write_busy_o
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	wire line_t pin_now = {scl_i, sda_i};
	wire line_t sync2_ff;
	line_t prev_ff;

	pin_sync #(
		.WIDTH($bits(line_t)),
		.IDLE(LINE_IDLE)
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i),
		.pin_i(pin_now),
		.sync_o(sync2_ff)
	);

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prev_ff <= LINE_IDLE;
		end else if (clk_en_i) begin
			prev_ff <= sync2_ff;
		end
	end

	// ----------------------------------------------------------------
	// bus event decode
	// ----------------------------------------------------------------
	wire scl_high = prev_ff.scl & sync2_ff.scl;
	wire start_det = scl_high & prev_ff.sda & ~sync2_ff.sda;
	wire stop_det = scl_high & ~prev_ff.sda & sync2_ff.sda;
	wire scl_rise = ~prev_ff.scl & sync2_ff.scl;
	wire scl_fall = prev_ff.scl & ~sync2_ff.scl;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	slave_state_t state_ff, nxt_state;
	logic [3:0] bit_cnt_ff, nxt_bit_cnt;
	logic [7:0] rx_ff, nxt_rx;
	logic [7:0] tx_ff, nxt_tx;
	mem_addr_t addr_ff, nxt_addr;
	logic ack_ff, nxt_ack;
	logic rd_ff, nxt_rd;
	logic sda_oe_ff, nxt_sda_oe;
	logic standby_ff;
	logic busy_ff;
	logic [TIMER_BITS-1:0] timer_ff;
	logic [PAGE_BYTES-1:0] page_mask_ff;
	logic [7:0] page_data_ff [PAGE_BYTES];
	logic [7:0] mem_ff [MEM_BYTES];

	wire receiving = (state_ff == ST_CMD) | (state_ff == ST_ZONE) | (state_ff == ST_ADDR) | (state_ff == ST_WDATA);
	wire active = receiving | (state_ff == ST_RDATA);
	wire [7:0] rx_byte = {rx_ff[6:0], sync2_ff.sda};
	wire data_rise = scl_rise & active & (bit_cnt_ff < ACK_SLOT);
	wire slot_rise = scl_rise & active & (bit_cnt_ff == ACK_SLOT);
	wire byte_done = data_rise & receiving & (bit_cnt_ff == LAST_DATA_BIT);
	wire zone_open = zone_grant_i[addr_ff.zone];
	wire wr_take = byte_done & (state_ff == ST_WDATA) & zone_open;
	wire commit_go = stop_det & ~busy_ff & (|page_mask_ff);
	wire host_ack = ~sync2_ff.sda;

	// ----------------------------------------------------------------
	// sequential read address, merging equal-requirement zones
	// ----------------------------------------------------------------
	function automatic mem_addr_t next_read_addr(input mem_addr_t a, input zone_req_t req);
		mem_addr_t n;
		n = a;
		if (a.offset != LAST_OFFSET) begin
			n.offset = a.offset + 7'h01;
		end else begin
			n.offset = 7'h00;
			if (a.zone != LAST_ZONE && req[a.zone + 4'h1] == req[a.zone]) begin
				n.zone = a.zone + 4'h1;
			end
		end
		return n;
	endfunction : next_read_addr

	wire mem_addr_t rd_next = next_read_addr(addr_ff, zone_req_i);
	wire [7:0] mem_now = mem_ff[addr_ff];
	wire [7:0] mem_next = mem_ff[rd_next];
	wire [7:0] tx_now = zone_open ? mem_now : RELEASED_BYTE;
	wire [7:0] tx_next = zone_grant_i[rd_next.zone] ? mem_next : RELEASED_BYTE;

	// ----------------------------------------------------------------
	// protocol next-state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_rx = rx_ff;
		nxt_tx = tx_ff;
		nxt_addr = addr_ff;
		nxt_ack = ack_ff;
		nxt_rd = rd_ff;
		nxt_sda_oe = sda_oe_ff;
		if (start_det && !busy_ff) begin
			nxt_state = ST_CMD;
			nxt_bit_cnt = 4'h0;
			nxt_ack = 1'b0;
			nxt_rd = 1'b0;
			nxt_sda_oe = 1'b0;
		end else if (start_det || stop_det) begin
			nxt_state = ST_IDLE;
			nxt_sda_oe = 1'b0;
		end else if (data_rise) begin
			nxt_rx = rx_byte;
			nxt_bit_cnt = bit_cnt_ff + 4'h1;
			if (state_ff == ST_RDATA) begin
				nxt_tx = {tx_ff[6:0], 1'b1};
			end
			if (byte_done) begin
				case (state_ff)
					ST_CMD: begin
						nxt_ack = 1'b1;
						nxt_rd = rx_byte[READ_FLAG_POS];
					end
					ST_ZONE: begin
						nxt_ack = 1'b1;
						nxt_addr.zone = rx_byte[3:0];
					end
					ST_ADDR: begin
						nxt_ack = 1'b1;
						nxt_addr.offset = rx_byte[6:0];
					end
					ST_WDATA: nxt_ack = zone_open;
					default: nxt_ack = 1'b0;
				endcase
			end
		end else if (slot_rise) begin
			nxt_bit_cnt = 4'h0;
			nxt_ack = 1'b0;
			case (state_ff)
				ST_CMD: begin
					nxt_state = rd_ff ? ST_RDATA : ST_ZONE;
					nxt_tx = tx_now;
				end
				ST_ZONE: nxt_state = ST_ADDR;
				ST_ADDR: nxt_state = ST_WDATA;
				ST_WDATA: begin
					nxt_state = ack_ff ? ST_WDATA : ST_WAIT;
					nxt_addr.offset = {addr_ff.offset[6:4], addr_ff.offset[3:0] + 4'h1};
				end
				ST_RDATA: begin
					nxt_addr = rd_next;
					nxt_tx = tx_next;
					nxt_state = host_ack ? ST_RDATA : ST_WAIT;
				end
				default: nxt_state = ST_WAIT;
			endcase
		end else if (scl_fall) begin
			if (receiving && bit_cnt_ff == ACK_SLOT) begin
				nxt_sda_oe = ack_ff;
			end else if (state_ff == ST_RDATA && bit_cnt_ff < ACK_SLOT) begin
				nxt_sda_oe = ~tx_ff[7];
			end else begin
				nxt_sda_oe = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			rx_ff <= 8'h00;
			tx_ff <= 8'hFF;
			addr_ff <= '0;
			ack_ff <= 1'b0;
			rd_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (clk_en_i) begin
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			rx_ff <= nxt_rx;
			tx_ff <= nxt_tx;
			addr_ff <= nxt_addr;
			ack_ff <= nxt_ack;
			rd_ff <= nxt_rd;
			sda_oe_ff <= nxt_sda_oe;
		end
	end

	// ----------------------------------------------------------------
	// standby and internal write timer
	// ----------------------------------------------------------------
	wire read_stop = stop_det & rd_ff & ((state_ff == ST_RDATA) | (state_ff == ST_WAIT));
	wire [TIMER_BITS-1:0] wr_load = TIMER_BITS'(WR_CYCLES - 1);

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			standby_ff <= 1'b1;
			busy_ff <= 1'b0;
			timer_ff <= '0;
		end else if (clk_en_i) begin
			if (read_stop) begin
				standby_ff <= 1'b1;
			end else if (start_det) begin
				standby_ff <= 1'b0;
			end
			if (commit_go) begin
				busy_ff <= 1'b1;
				timer_ff <= wr_load;
			end else if (busy_ff) begin
				timer_ff <= timer_ff - TIMER_BITS'(1);
				busy_ff <= (timer_ff != '0);
			end
		end
	end

	// ----------------------------------------------------------------
	// page buffer and user memory
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			page_mask_ff <= '0;
		end else if (clk_en_i) begin
			if (commit_go || (start_det && !busy_ff && !(|page_mask_ff))) begin
				page_mask_ff <= '0;
			end else if (wr_take) begin
				page_mask_ff[addr_ff.offset[3:0]] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (clk_en_i) begin
			if (wr_take) begin
				page_data_ff[addr_ff.offset[3:0]] <= rx_byte;
			end
			if (commit_go) begin
				for (int i = 0; i < PAGE_BYTES; i++) begin
					if (page_mask_ff[i]) begin
						mem_ff[{addr_ff.zone, addr_ff.offset[6:4], 4'(i)}] <= page_data_ff[i];
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign sda_o = 1'b0;
	assign sda_oe_o = sda_oe_ff;
	assign standby_o = standby_ff;
	assign write_busy_o = busy_ff;

endmodule : two_wire_eeprom_slave

// ----------------------------------------------------------------
// two-stage pin synchroniser
// ----------------------------------------------------------------
module pin_sync
	import two_wire_eeprom_pkg::*;
#(
	parameter int unsigned WIDTH = 2,
	parameter logic [WIDTH-1:0] IDLE = '1
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stage1_ff <= IDLE;
			stage2_ff <= IDLE;
		end else if (clk_en_i) begin
			stage1_ff <= pin_i;
			stage2_ff <= stage1_ff;
		end
	end

	assign sync_o = stage2_ff;

endmodule : pin_sync

//--- two_wire_eeprom_slave_monitor.sv
/* assertions on the two-wire slave pins and flags.
   bound to every slave instance; one clock domain. */
`timescale 1ns/10ps
module two_wire_eeprom_monitor
	import two_wire_eeprom_pkg::*;
#(
	parameter int unsigned WR_CYCLES = INTERNAL_WRITE_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic standby_o,
	input wire logic write_busy_o
);
	logic [TIMER_BITS-1:0] busy_cnt_ff;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			busy_cnt_ff <= '0;
		else
			busy_cnt_ff <= write_busy_o ? (clk_en_i ? busy_cnt_ff + 1'b1 : busy_cnt_ff) : '0;
	end
	open_drain_a: assert property (sda_o == 1'b0)
		else $error("data driven high");
	oe_low_phase_a: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("oe moved with clock high");
	oe_sync_lag_a: assert property ($fell(scl_i) |=> $stable(sda_oe_o))
		else $error("oe moved too early");
	start_wake_a: assert property ($fell(sda_i) && scl_i && $past(scl_i) && !write_busy_o |-> ##[1:6] !standby_o)
		else $error("start kept standby");
	stop_sleep_a: assert property ($rose(standby_o) |-> scl_i && sda_i)
		else $error("standby without stop");
	busy_len_a: assert property ($fell(write_busy_o) |-> busy_cnt_ff == TIMER_BITS'(WR_CYCLES))
		else $error("write time wrong");
	busy_at_stop_a: assert property ($rose(write_busy_o) |-> scl_i && sda_i)
		else $error("write without stop");
	busy_quiet_a: assert property (write_busy_o |-> !sda_oe_o)
		else $error("ack while busy");
	standby_quiet_a: assert property (standby_o |-> !sda_oe_o)
		else $error("line held in standby");
endmodule : two_wire_eeprom_monitor
bind two_wire_eeprom_slave two_wire_eeprom_monitor #(.WR_CYCLES(WR_CYCLES)) u_mon (.clk_sys_i(clk_sys_i),
	.sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.standby_o(standby_o), .write_busy_o(write_busy_o));

//--- two_wire_host.sv
/* host on the two-wire bus: drives the clock, pulls data low.
   assumes the device output is open drain and a pull-up on data. */
`timescale 1ns/10ps
module two_wire_host (
	input wire logic clk_i,
	input wire logic dev_oe_i,
	input wire logic dev_dat_i,
	output logic scl_o,
	output logic sda_o
);
	logic scl_ff = 1'b1;
	logic low_ff = 1'b0;
	logic [8:0] obs;
	event done;
	assign scl_o = scl_ff;
	assign sda_o = !low_ff && (!dev_oe_i || dev_dat_i);
	task w(input int n);
		repeat (n) @(posedge clk_i);
	endtask : w
	task bit_io(input logic b, output logic r);
		w(4);
		low_ff <= !b;
		w(4);
		scl_ff <= 1'b1;
		w(8);
		r = sda_o;
		scl_ff <= 1'b0;
	endtask : bit_io
	task xb(input logic [8:0] v);
		for (int i = 8; i >= 0; i--)
			bit_io(v[i], obs[i]);
		->done;
	endtask : xb
	task pulses(input int n);
		logic r;
		repeat (n) bit_io(1'b1, r);
	endtask : pulses
	task frame(input logic s);
		w(4);
		low_ff <= !s;
		w(8);
		scl_ff <= 1'b1;
		w(8);
		low_ff <= s;
		w(8);
		if (s)
			scl_ff <= 1'b0;
	endtask : frame
endmodule : two_wire_host

//--- secure_eeprom_two_wire_slave_bench.sv
/* bench for the two-wire slave with a host model.
   assumes a short write time parameter. */
`timescale 1ns/10ps
module secure_eeprom_two_wire_slave_bench
	import two_wire_eeprom_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic clk_en = 1'b1;
	logic [ZONE_COUNT-1:0] zone_grant_i = 16'hFFDF;
	zone_req_t zone_req_i = '0;
	logic scl, sda, sda_o, sda_oe_o, standby_o, write_busy_o;
	logic [31:0] rnd = 32'h00014538;
	logic [8:0] exp_q[$];
	int fail_count = 0;
	int n_checks = 0;
	two_wire_eeprom_slave #(.WR_CYCLES(240)) DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.zone_grant_i(zone_grant_i), .zone_req_i(zone_req_i), .standby_o(standby_o),
		.write_busy_o(write_busy_o));
	two_wire_host host (.clk_i(clk_sys_i), .dev_oe_i(sda_oe_o), .dev_dat_i(sda_o), .scl_o(scl), .sda_o(sda));
	initial forever #12.5 clk_sys_i = !clk_sys_i;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task chk(input logic got, input logic want);
		n_checks++;
		if (got !== want) begin
			fail_count++;
			$display("Error %0t: flag mismatch", $time);
		end
	endtask : chk
	task send(input logic [7:0] d, input logic ack);
		exp_q.push_back({d, !ack});
		host.xb({d, 1'b1});
	endtask : send
	task rd(input logic [7:0] d, input logic last);
		exp_q.push_back({d, last});
		host.xb({8'hFF, last});
	endtask : rd
	task wr(input logic [3:0] z, input logic [6:0] o, input logic [7:0] d0, input logic [7:0] d1, input logic ok);
		host.frame(1'b1);
		send(8'h00, 1'b1);
		send({4'h0, z}, 1'b1);
		send({1'b0, o}, 1'b1);
		send(d0, ok);
		send(d1, ok);
		host.frame(1'b0);
	endtask : wr
	task wait_idle;
		for (int i = 0; i < 1000 && write_busy_o !== 1'b0; i++)
			@(posedge clk_sys_i);
		if (write_busy_o !== 1'b0) begin
			fail_count++;
			complete_run();
		end
	endtask : wait_idle
	initial forever begin
		@(host.done);
		n_checks++;
		if (exp_q.size() == 0 || host.obs !== exp_q[0]) begin
			fail_count++;
			$display("Error %0t: byte %h", $time, host.obs);
		end
		if (exp_q.size() > 0)
			void'(exp_q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fail_count++;
		complete_run();
	end
	initial begin
		logic [7:0] a, b, c;
		repeat (8) @(posedge clk_sys_i);
		rnd = lfsr(rnd);
		{a, b, c} = rnd[23:0];
		sys_rst_i <= 1'b0;
		zone_req_i <= {16{rnd[31:24]}};
		zone_grant_i <= (rnd[15:0] | 16'h0018) & 16'hFFDF;
		@(posedge clk_sys_i);
		#1;
		chk(standby_o, 1'b1);
		chk(write_busy_o, 1'b0);
		chk(sda_oe_o, 1'b0);
		$display("test reset done");
		host.pulses(9);
		wr(4'h4, 7'h00, c, b, 1'b1);
		#1;
		chk(write_busy_o, 1'b1);
		host.frame(1'b1);
		send(8'h00, 1'b0);
		host.frame(1'b0);
		clk_en <= 1'b0;
		repeat (4 + rnd[1:0]) @(posedge clk_sys_i);
		clk_en <= 1'b1;
		wait_idle();
		$display("test write done");
		wr(4'h3, 7'h7E, a, b, 1'b1);
		wait_idle();
		host.frame(1'b1);
		send(8'h00, 1'b1);
		send(8'h03, 1'b1);
		send(8'h7E, 1'b1);
		host.frame(1'b1);
		send(8'h01, 1'b1);
		rd(a, 1'b0);
		rd(b, 1'b0);
		rd(c, 1'b1);
		host.frame(1'b0);
		#1;
		chk(standby_o, 1'b1);
		$display("test read done");
		wr(4'h5, 7'h00, a, b, 1'b0);
		wait_idle();
		host.frame(1'b1);
		send(8'h00, 1'b1);
		send(8'h05, 1'b1);
		send(8'h00, 1'b1);
		host.frame(1'b1);
		send(8'h01, 1'b1);
		rd(8'hFF, 1'b1);
		host.frame(1'b0);
		#1;
		chk(standby_o, 1'b1);
		$display("test refusal done");
		complete_run();
	end
endmodule : secure_eeprom_two_wire_slave_bench
